// file: shared/uart_sc_defs.svh
// constants for the serial port status and control block
`ifndef UART_SC_DEFS_SVH
`define UART_SC_DEFS_SVH
`define CLK_HZ 100000000
`define BAUD_BPS 115200
`define OVERSAMPLE 16
`define TICK_DIV_DEFAULT (`CLK_HZ / (`BAUD_BPS * `OVERSAMPLE))
`define DIV_W 16
`define TX_DEPTH_DEFAULT 4
`define RX_DEPTH_DEFAULT 4
`define OFS_STATUS 4'h0
`define OFS_MODE 4'h4
`define OFS_TXDATA 4'h8
`define OFS_RXDATA 4'hC
`define B_TXSEL1 15
`define B_TXPOL 14
`define B_TXSEL0 13
`define B_BRK 11
`define B_TXEN 10
`define B_TXBF 9
`define B_TX_ALL_DONE_FLAG 8
`define B_RXSEL1 7
`define B_RXSEL0 6
`define B_ADDRESS_DETECT_ENABLE 5
`define B_RECEIVER_IDLE_FLAG 4
`define B_PARITY_ERROR_FLAG 3
`define B_FRAMING_ERROR_FLAG 2
`define B_OVERRUN_ERROR_FLAG 1
`define B_RXDA 0
`define B_INFRARED_CODEC_ENABLE 12
`define B_PDSEL1 2
`define B_PDSEL0 1
`define B_STSEL 0
`define TXSEL_EACH 2'h0
`define TXSEL_DONE 2'h1
`define TXSEL_EMPTY 2'h2
`define RXSEL_FULL 2'h3
`define RXSEL_3Q 2'h2
`define PD_EVEN 2'h1
`define PD_ODD 2'h2
`define PD_9BIT 2'h3
`define BRK_BITS 4'hC
`define OS_MID 4'h7
`define OS_LAST 4'hF
`endif

// file: shared/uart_sc_pkg.sv
// types for the serial port status and control block
package uart_sc_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avs_req_t;
   typedef struct packed {
      logic [8:0] data;
      logic parity_error_flag;
      logic framing_error_flag;
   } rx_entry_t;
   typedef struct packed {
      logic waitreq;
      logic [15:0] rdata;
      logic [1:0] tx_irq_select;
      logic tx_idle_polarity;
      logic send_break_request;
      logic transmit_enable_bit;
      logic [1:0] rx_irq_select;
      logic address_detect_enable;
      logic overrun_error_flag;
      logic infrared_codec_enable;
      logic [1:0] parity_data_select;
      logic two_stop;
      logic [15:0] div_cnt;
      tx_state_t tx_st;
      logic [3:0] tx_os;
      logic [3:0] tx_bit;
      logic [8:0] tx_shift_register;
      logic tx_par;
      logic tx_brk;
      rx_state_t rx_st;
      logic [3:0] rx_os;
      logic [3:0] rx_bit;
      logic [8:0] rx_shift_register;
      logic rx_par;
      logic pin;
      logic oe;
      logic tx_irq;
      logic rx_irq;
   } core_state_t;
endpackage

// file: src/uart_sc_fifo.sv
// small register fifo whose head entry comes straight out of a register
`timescale 1ns/1ps
module uart_sc_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 4,
   parameter int CW = $clog2(DEPTH + 1)
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic push_in,
   input wire logic [WIDTH-1:0] push_data_in,
   input wire logic pop_in,
   input wire logic flush_in,
   output logic [WIDTH-1:0] head_out,
   output logic [CW-1:0] count_out
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [CW-1:0] count;
   } fifo_state_t;

   fifo_state_t s;
   fifo_state_t n;
   logic do_pop;
   logic do_push;

   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_cfg
      $error("fifo depth must be at least 2");
   end

   // shift-down organisation keeps the head in entry 0, so the head is a plain register
   always_comb begin
      n = s;
      do_pop = pop_in && (s.count != '0);
      do_push = push_in && ((s.count != CW'(DEPTH)) || do_pop);
      if (do_pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            n.mem[i] = s.mem[i+1];
         end
         n.count = s.count - CW'(1);
      end
      if (do_push) begin
         n.mem[n.count] = push_data_in;
         n.count = n.count + CW'(1);
      end
      if (flush_in) begin
         n.count = '0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign head_out = s.mem[0];
   assign count_out = s.count;
endmodule

// file: src/uart_status_control.sv
// serial port with status and control register, reached over an avalon-mm slave
//
// Functional notes
// - select 00: transmit interrupt each time a character enters the shift register.
// - select 10: interrupt on entry to shift register only if buffer becomes empty.
// - select 01: interrupt when last character fully shifted out, nothing queued.
// - polarity bit sets idle level; meaning flips with infrared codec on.
// - break request sends start, twelve zeros, stop; hardware then clears request.
// - transmit enable drives pin; clearing aborts, empties buffer, releases pin.
// - buffer full flag is 1 only when no transmit slot is free.
// - all done flag is 1 when shift register and buffer empty; resets to 1.
// - receive select 11: interrupt when a transfer makes buffer hold four characters.
// - receive select 10: interrupt when a transfer makes buffer hold three characters.
// - receive select 00 or 01: interrupt on every transfer into buffer.
// - address detect keeps only bit-8-set characters, and only in nine-bit mode.
// - receiver idle flag is 1 while idle, 0 while receiving; resets to 1.
// - parity error flag belongs to the character at the fifo head.
// - framing error flag belongs to the character at the fifo head.
// - overflow sets overrun flag; software clear empties buffer and shift register.
// - data available flag is 1 while the receive buffer holds a character.
// - status bit 12 always reads zero.
// - parity/data select 11 means nine data bits with no parity.
// - reading receive data advances fifo, bringing next character and its flags.
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "uart_sc_defs.svh"
module uart_status_control import uart_sc_pkg::*; #(
   parameter int TICK_DIV = `TICK_DIV_DEFAULT,
   parameter int TX_DEPTH = `TX_DEPTH_DEFAULT,
   parameter int RX_DEPTH = `RX_DEPTH_DEFAULT
) (
   input wire logic CLK_SYS_IN,
   input wire logic RST_B_IN,
   input wire logic [3:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic RX_PIN_IN,
   output logic SERIAL_OUT_PIN_OUT,
   output logic SERIAL_OUT_OE_OUT,
   output logic TX_IRQ_OUT,
   output logic RX_IRQ_OUT
);
   localparam int TCW = $clog2(TX_DEPTH + 1);
   localparam int RCW = $clog2(RX_DEPTH + 1);

   if (TICK_DIV < 1 || TICK_DIV > 65535 || TX_DEPTH < 2 || RX_DEPTH < 4 || (RX_DEPTH % 4) != 0) begin : g_bad_cfg
      $error("unsupported divider or fifo depth");
   end

   core_state_t s;
   core_state_t n;
   avs_req_t req;
   rx_entry_t rx_head;
   rx_entry_t rx_new;
   logic [8:0] tx_head;
   logic [TCW-1:0] tx_count;
   logic [RCW-1:0] rx_count;
   logic [RCW-1:0] rx_level;
   logic [15:0] status_word;
   logic [15:0] mode_word;
   logic [15:0] wmask;
   logic [15:0] nv_status;
   logic [15:0] nv_mode;
   logic [3:0] tx_nbits;
   logic [3:0] rx_nbits;
   logic tick;
   logic nine;
   logic par_en;
   logic odd;
   logic inv;
   logic tx_line;
   logic busy_req;
   logic wr_acc;
   logic rd_acc;
   logic tx_full;
   logic tx_empty;
   logic rx_full;
   logic rx_empty;
   logic tx_push;
   logic tx_pop;
   logic tx_flush;
   logic rx_push;
   logic rx_pop;
   logic rx_flush;

   assign req = '{AVS_ADDRESS_IN, AVS_READ_IN, AVS_WRITE_IN, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN};
   assign busy_req = req.read | req.write;
   // a request is taken at the edge where waitrequest is seen low
   assign wr_acc = req.write & ~s.waitreq;
   assign rd_acc = req.read & ~s.waitreq;
   assign wmask = {{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
   assign nv_status = (status_word & ~wmask) | (req.writedata[15:0] & wmask);
   assign nv_mode = (mode_word & ~wmask) | (req.writedata[15:0] & wmask);

   assign tick = s.div_cnt == 16'h0000;
   assign nine = s.parity_data_select == `PD_9BIT;
   assign par_en = (s.parity_data_select == `PD_EVEN) || (s.parity_data_select == `PD_ODD);
   assign odd = s.parity_data_select == `PD_ODD;
   assign tx_nbits = s.tx_brk ? `BRK_BITS : (nine ? 4'h9 : 4'h8);
   assign rx_nbits = nine ? 4'h9 : 4'h8;
   // with the codec off a set bit inverts the line; with it on the sense flips
   assign inv = s.infrared_codec_enable ? ~s.tx_idle_polarity : s.tx_idle_polarity;

   assign tx_full = tx_count == TCW'(TX_DEPTH);
   assign tx_empty = tx_count == '0;
   assign rx_full = rx_count == RCW'(RX_DEPTH);
   assign rx_empty = rx_count == '0;

   always_comb begin
      status_word = 16'h0000;
      status_word[`B_TXSEL1] = s.tx_irq_select[1];
      status_word[`B_TXPOL] = s.tx_idle_polarity;
      status_word[`B_TXSEL0] = s.tx_irq_select[0];
      status_word[`B_BRK] = s.send_break_request;
      status_word[`B_TXEN] = s.transmit_enable_bit;
      status_word[`B_TXBF] = tx_full;
      status_word[`B_TX_ALL_DONE_FLAG] = tx_empty && (s.tx_st == TX_IDLE);
      status_word[`B_RXSEL1] = s.rx_irq_select[1];
      status_word[`B_RXSEL0] = s.rx_irq_select[0];
      status_word[`B_ADDRESS_DETECT_ENABLE] = s.address_detect_enable;
      status_word[`B_RECEIVER_IDLE_FLAG] = s.rx_st == RX_IDLE;
      status_word[`B_PARITY_ERROR_FLAG] = ~rx_empty & rx_head.parity_error_flag;
      status_word[`B_FRAMING_ERROR_FLAG] = ~rx_empty & rx_head.framing_error_flag;
      status_word[`B_OVERRUN_ERROR_FLAG] = s.overrun_error_flag;
      status_word[`B_RXDA] = ~rx_empty;
      mode_word = 16'h0000;
      mode_word[`B_INFRARED_CODEC_ENABLE] = s.infrared_codec_enable;
      mode_word[`B_PDSEL1] = s.parity_data_select[1];
      mode_word[`B_PDSEL0] = s.parity_data_select[0];
      mode_word[`B_STSEL] = s.two_stop;
   end

   always_comb begin
      case (s.tx_st)
         TX_START: tx_line = 1'b0;
         TX_DATA: tx_line = ~s.tx_brk & s.tx_shift_register[0];
         TX_PARITY: tx_line = s.tx_par;
         default: tx_line = 1'b1;
      endcase
   end

   assign rx_level = rx_count - RCW'(rx_pop) + RCW'(1);

   always_comb begin
      n = s;
      n.tx_irq = 1'b0;
      n.rx_irq = 1'b0;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      tx_flush = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      rx_flush = 1'b0;
      rx_new = '0;
      n.div_cnt = tick ? `DIV_W'(TICK_DIV - 1) : s.div_cnt - 16'h0001;

      ////////////////////////////////////////////////////////////////////////////////
      // register bus: waitrequest drops one cycle after a request appears
      n.waitreq = ~(busy_req & s.waitreq);
      if (req.read & s.waitreq) begin
         case (req.address)
            `OFS_STATUS: n.rdata = status_word;
            `OFS_MODE: n.rdata = mode_word;
            `OFS_RXDATA: n.rdata = {7'h00, rx_head.data};
            default: n.rdata = 16'h0000;
         endcase
      end
      if (rd_acc && (req.address == `OFS_RXDATA)) begin
         rx_pop = ~rx_empty;
      end
      if (wr_acc) begin
         case (req.address)
            `OFS_STATUS: begin
               n.tx_irq_select = {nv_status[`B_TXSEL1], nv_status[`B_TXSEL0]};
               n.tx_idle_polarity = nv_status[`B_TXPOL];
               n.send_break_request = nv_status[`B_BRK];
               n.transmit_enable_bit = nv_status[`B_TXEN];
               n.rx_irq_select = {nv_status[`B_RXSEL1], nv_status[`B_RXSEL0]};
               n.address_detect_enable = nv_status[`B_ADDRESS_DETECT_ENABLE];
            end
            `OFS_MODE: begin
               n.infrared_codec_enable = nv_mode[`B_INFRARED_CODEC_ENABLE];
               n.parity_data_select = {nv_mode[`B_PDSEL1], nv_mode[`B_PDSEL0]};
               n.two_stop = nv_mode[`B_STSEL];
            end
            `OFS_TXDATA: tx_push = wmask[0] & ~tx_full;
            default: ;
         endcase
      end

      ////////////////////////////////////////////////////////////////////////////////
      // transmitter
      case (s.tx_st)
         TX_IDLE: begin
            if (s.transmit_enable_bit && !tx_empty) begin
               tx_pop = 1'b1;
               n.tx_shift_register = tx_head;
               n.tx_brk = s.send_break_request;
               n.tx_par = odd;
               n.tx_os = 4'h0;
               n.tx_bit = 4'h0;
               n.tx_st = TX_START;
               if (s.tx_irq_select == `TXSEL_EACH) begin
                  n.tx_irq = 1'b1;
               end
               if (s.tx_irq_select == `TXSEL_EMPTY && tx_count == TCW'(1) && !tx_push) begin
                  n.tx_irq = 1'b1;
               end
            end
         end
         TX_START, TX_DATA, TX_PARITY, TX_STOP: begin
            if (tick) begin
               n.tx_os = s.tx_os + 4'h1;
            end
            if (tick && s.tx_os == `OS_LAST) begin
               case (s.tx_st)
                  TX_START: n.tx_st = TX_DATA;
                  TX_DATA: begin
                     n.tx_shift_register = {1'b0, s.tx_shift_register[8:1]};
                     n.tx_par = s.tx_par ^ s.tx_shift_register[0];
                     n.tx_bit = s.tx_bit + 4'h1;
                     if (s.tx_bit == tx_nbits - 4'h1) begin
                        n.tx_bit = 4'h0;
                        n.tx_st = (par_en && !s.tx_brk) ? TX_PARITY : TX_STOP;
                     end
                  end
                  TX_PARITY: n.tx_st = TX_STOP;
                  default: begin
                     n.tx_bit = s.tx_bit + 4'h1;
                     if (s.tx_brk || !s.two_stop || s.tx_bit == 4'h1) begin
                        n.tx_st = TX_IDLE;
                        if (s.tx_brk) begin
                           n.send_break_request = 1'b0;
                        end
                        if (s.tx_irq_select == `TXSEL_DONE && tx_empty && !tx_push) begin
                           n.tx_irq = 1'b1;
                        end
                     end
                  end
               endcase
            end
         end
         default: n.tx_st = TX_IDLE;
      endcase
      // dropping enable aborts the frame and empties the queue
      if (s.transmit_enable_bit && !n.transmit_enable_bit) begin
         tx_flush = 1'b1;
         tx_pop = 1'b0;
         n.tx_st = TX_IDLE;
         n.tx_irq = 1'b0;
      end
      n.pin = tx_line ^ inv;
      n.oe = n.transmit_enable_bit;

      ////////////////////////////////////////////////////////////////////////////////
      // receiver, sampling at mid-bit on the oversampling tick
      case (s.rx_st)
         RX_IDLE: begin
            if (tick && !RX_PIN_IN) begin
               n.rx_os = 4'h0;
               n.rx_st = RX_START;
            end
         end
         RX_START: begin
            if (tick) begin
               n.rx_os = s.rx_os + 4'h1;
               if (s.rx_os == `OS_MID) begin
                  // a glitch shorter than half a bit is not a start bit
                  n.rx_st = RX_PIN_IN ? RX_IDLE : RX_DATA;
                  n.rx_os = 4'h0;
                  n.rx_bit = 4'h0;
                  n.rx_par = 1'b0;
                  n.rx_shift_register = 9'h000;
               end
            end
         end
         RX_DATA, RX_PARITY, RX_STOP: begin
            if (tick) begin
               n.rx_os = s.rx_os + 4'h1;
            end
            if (tick && s.rx_os == `OS_LAST) begin
               case (s.rx_st)
                  RX_DATA: begin
                     n.rx_shift_register[s.rx_bit] = RX_PIN_IN;
                     n.rx_par = s.rx_par ^ RX_PIN_IN;
                     n.rx_bit = s.rx_bit + 4'h1;
                     if (s.rx_bit == rx_nbits - 4'h1) begin
                        n.rx_st = par_en ? RX_PARITY : RX_STOP;
                     end
                  end
                  RX_PARITY: begin
                     n.rx_par = s.rx_par ^ RX_PIN_IN;
                     n.rx_st = RX_STOP;
                  end
                  default: begin
                     n.rx_st = RX_IDLE;
                     rx_new.data = s.rx_shift_register;
                     rx_new.parity_error_flag = par_en & (s.rx_par ^ odd);
                     rx_new.framing_error_flag = ~RX_PIN_IN;
                     if (s.overrun_error_flag) begin
                        rx_push = 1'b0;
                     end else if (s.address_detect_enable && nine && !s.rx_shift_register[8]) begin
                        rx_push = 1'b0;
                     end else if (rx_full && !rx_pop) begin
                        n.overrun_error_flag = 1'b1;
                     end else begin
                        rx_push = 1'b1;
                        case (s.rx_irq_select)
                           `RXSEL_FULL: n.rx_irq = rx_level == RCW'(RX_DEPTH);
                           `RXSEL_3Q: n.rx_irq = rx_level == RCW'(RX_DEPTH * 3 / 4);
                           default: n.rx_irq = 1'b1;
                        endcase
                     end
                  end
               endcase
            end
         end
         default: n.rx_st = RX_IDLE;
      endcase
      // setting only happens while clear and clearing only while set, so neither can mask the other
      if (wr_acc && req.address == `OFS_STATUS && s.overrun_error_flag && wmask[`B_OVERRUN_ERROR_FLAG] &&
          !req.writedata[`B_OVERRUN_ERROR_FLAG]) begin
         n.overrun_error_flag = 1'b0;
         rx_flush = 1'b1;
         rx_push = 1'b0;
         n.rx_irq = 1'b0;
         n.rx_st = RX_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register and storage

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         s <= '0;
         s.waitreq <= 1'b1;
         s.pin <= 1'b1;
      end else begin
         s <= n;
      end
   end

   uart_sc_fifo #(.WIDTH(9), .DEPTH(TX_DEPTH), .CW(TCW)) u_tx_fifo (
      .clk_in(CLK_SYS_IN),
      .rst_b_in(RST_B_IN),
      .push_in(tx_push),
      .push_data_in(req.writedata[8:0]),
      .pop_in(tx_pop),
      .flush_in(tx_flush),
      .head_out(tx_head),
      .count_out(tx_count)
   );

   uart_sc_fifo #(.WIDTH($bits(rx_entry_t)), .DEPTH(RX_DEPTH), .CW(RCW)) u_rx_fifo (
      .clk_in(CLK_SYS_IN),
      .rst_b_in(RST_B_IN),
      .push_in(rx_push),
      .push_data_in(rx_new),
      .pop_in(rx_pop),
      .flush_in(rx_flush),
      .head_out(rx_head),
      .count_out(rx_count)
   );

   assign AVS_READDATA_OUT = {16'h0000, s.rdata};
   assign AVS_WAITREQUEST_OUT = s.waitreq;
   assign SERIAL_OUT_PIN_OUT = s.pin;
   assign SERIAL_OUT_OE_OUT = s.oe;
   assign TX_IRQ_OUT = s.tx_irq;
   assign RX_IRQ_OUT = s.rx_irq;
endmodule

// file: dv/uart_sc_props.sv
// assertions on the register bus and serial pins of the status and control block
`timescale 1ns/1ps
module uart_sc_props (
   input wire logic CLK_SYS_IN,
   input wire logic RST_B_IN,
   input wire logic [3:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   input wire logic [31:0] AVS_READDATA_OUT,
   input wire logic AVS_WAITREQUEST_OUT,
   input wire logic SERIAL_OUT_OE_OUT,
   input wire logic TX_IRQ_OUT,
   input wire logic RX_IRQ_OUT
);
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_B_IN);
   logic st_rd;
   logic st_wr;
   // status accesses complete at the edge where waitrequest is sampled low
   assign st_rd = AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 4'h0;
   assign st_wr = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 4'h0;
   //////////////////////////////////////////////////////////////////////////////
   chk_wait_one: assert property ($fell(AVS_WAITREQUEST_OUT) |=> AVS_WAITREQUEST_OUT)
      else $error("waitrequest low longer than one cycle");
   chk_answer_delay: assert property (($rose(AVS_READ_IN) || $rose(AVS_WRITE_IN)) |=> !AVS_WAITREQUEST_OUT)
      else $error("answer not after one wait cycle");
   chk_idle_wait: assert property (!(AVS_READ_IN || AVS_WRITE_IN) |-> AVS_WAITREQUEST_OUT)
      else $error("waitrequest low while idle");
   chk_bit_twelve: assert property (st_rd |-> AVS_READDATA_OUT[31:16] == 16'h0 && !AVS_READDATA_OUT[12])
      else $error("unused status bits not zero");
   chk_full_done: assert property (st_rd |-> !(AVS_READDATA_OUT[9] && AVS_READDATA_OUT[8]))
      else $error("buffer full and all done together");
   chk_empty_noerr: assert property (st_rd && !AVS_READDATA_OUT[0] |-> AVS_READDATA_OUT[3:2] == 2'h0)
      else $error("error flags without data");
   chk_txirq_pulse: assert property (TX_IRQ_OUT |=> !TX_IRQ_OUT)
      else $error("transmit interrupt longer than a pulse");
   chk_rxirq_pulse: assert property (RX_IRQ_OUT |=> !RX_IRQ_OUT)
      else $error("receive interrupt longer than a pulse");
   chk_oe_drop: assert property (st_wr && AVS_BYTEENABLE_IN[1] && !AVS_WRITEDATA_IN[10]
      |-> ##[1:2] !SERIAL_OUT_OE_OUT)
      else $error("pin still driven after transmit disable");
endmodule

// file: dv/uart_sc_peer.sv
// remote serial peer: decodes the transmit line and sends frames on the receive line
`timescale 1ns/1ps
module uart_sc_peer (
   input wire logic clk_in,
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] got[$];
   int low_run = 0;
   int max_low = 0;
   initial line_out = 1'b1;
   // longest low stretch, used to measure a break
   always @(posedge clk_in) begin
      low_run <= line_in ? 0 : low_run + 1;
      if (!line_in && low_run + 1 > max_low) max_low <= low_run + 1;
   end
   // each bit is sampled at its middle, sixteen clocks a bit
   initial forever begin
      logic [7:0] b;
      @(negedge line_in);
      repeat (8) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
         repeat (16) @(posedge clk_in);
         b[i] = line_in;
      end
      repeat (16) @(posedge clk_in);
      got.push_back(b);
   end
   task automatic send(input logic [8:0] v, input int n, input logic stop);
      line_out <= 1'b0;
      repeat (16) @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         line_out <= v[i];
         repeat (16) @(posedge clk_in);
      end
      line_out <= stop;
      repeat (16) @(posedge clk_in);
      line_out <= 1'b1;
      repeat (16) @(posedge clk_in);
   endtask
endmodule

// file: dv/testbench.sv
// self-checking bench for the serial port status and control block
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] rdata;
   logic [31:0] q;
   logic waitreq, pin, oe, txirq, rxirq, rx_pin;
   logic [7:0] d[5];
   int fails = 0;
   int total_checks = 0;
   int ntx = 0;
   int nrx = 0;
   int n0;
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      if (txirq === 1'b1) ntx++;
      if (rxirq === 1'b1) nrx++;
   end
   uart_status_control #(.TICK_DIV(1)) uart_status_control_i (.CLK_SYS_IN(clk), .RST_B_IN(rst_b),
      .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
      .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
      .RX_PIN_IN(rx_pin), .SERIAL_OUT_PIN_OUT(pin), .SERIAL_OUT_OE_OUT(oe), .TX_IRQ_OUT(txirq),
      .RX_IRQ_OUT(rxirq));
   uart_sc_peer uart_sc_peer_i (.clk_in(clk), .line_in(pin), .line_out(rx_pin));
   //////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
      int n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= v;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 100);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 100) begin
         fails++;
         complete_run();
      end
   endtask
   function automatic logic even_par(input logic [7:0] b);
      return ^b;
   endfunction
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      static logic [1:0] sels[3] = '{2'h0, 2'h2, 2'h1};
      static int exp_tx[3] = '{5, 2, 1};
      static logic [1:0] rsel[3] = '{2'h0, 2'h2, 2'h3};
      static int exp_rx[3] = '{4, 1, 1};
      static logic [1:0] pe[3] = '{2'h0, 2'h2, 2'h1};
      void'($urandom(66506));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      bus(0, 4'h0, 0);
      check(q, 32'h0110);
      $display("reset values test done");
      for (int s = 0; s < 3; s++) begin
         bus(1, 4'h0, {16'h0, sels[s][1], 1'b0, sels[s][0], 13'h0400});
         n0 = ntx;
         uart_sc_peer_i.got.delete();
         for (int i = 0; i < 5; i++) begin
            d[i] = 8'($urandom);
            bus(1, 4'h8, {24'h0, d[i]});
         end
         bus(0, 4'h0, 0);
         check(q[9:8], 2'h2);
         for (int w = 0; w < 2000 && uart_sc_peer_i.got.size() < 5; w++) @(posedge clk);
         check(uart_sc_peer_i.got.size(), 5);
         repeat (30) @(posedge clk);
         for (int i = 0; i < 5; i++) check(uart_sc_peer_i.got[i], d[i]);
         check(ntx - n0, exp_tx[s]);
         bus(0, 4'h0, 0);
         check(q[9:8], 2'h1);
      end
      $display("transmit interrupt modes test done");
      for (int s = 0; s < 3; s++) begin
         bus(1, 4'h0, {24'h0, rsel[s], 6'h0});
         n0 = nrx;
         for (int i = 0; i < 4; i++) begin
            d[i] = 8'($urandom);
            uart_sc_peer_i.send({1'b0, d[i]}, 8, 1'b1);
         end
         check(nrx - n0, exp_rx[s]);
         bus(0, 4'h0, 0);
         check(q[0], 1'b1);
         for (int i = 0; i < 4; i++) begin
            bus(0, 4'hC, 0);
            check(q, {24'h0, d[i]});
         end
         bus(0, 4'h0, 0);
         check(q[4:0], 5'h10);
      end
      $display("receive interrupt modes test done");
      bus(1, 4'h0, 0);
      for (int i = 0; i < 5; i++) uart_sc_peer_i.send({1'b0, d[i]}, 8, 1'b1);
      bus(0, 4'h0, 0);
      check(q[1:0], 2'h3);
      bus(0, 4'hC, 0);
      check(q, {24'h0, d[0]});
      n0 = nrx;
      uart_sc_peer_i.send({1'b0, d[1]}, 8, 1'b1);
      check(nrx - n0, 0);
      bus(1, 4'h0, 0);
      bus(0, 4'h0, 0);
      check(q[1:0], 2'h0);
      $display("overrun test done");
      bus(1, 4'h4, 32'h2);
      for (int i = 0; i < 3; i++) d[i] = 8'($urandom);
      uart_sc_peer_i.send({even_par(d[0]), d[0]}, 9, 1'b1);
      uart_sc_peer_i.send({~even_par(d[1]), d[1]}, 9, 1'b1);
      uart_sc_peer_i.send({even_par(d[2]), d[2]}, 9, 1'b0);
      for (int i = 0; i < 3; i++) begin
         bus(0, 4'h0, 0);
         check(q[3:2], pe[i]);
         bus(0, 4'hC, 0);
         check(q[7:0], d[i]);
      end
      $display("error flags test done");
      bus(1, 4'h4, 32'h6);
      bus(1, 4'h0, 32'h20);
      uart_sc_peer_i.send({1'b0, d[0]}, 9, 1'b1);
      uart_sc_peer_i.send({1'b1, d[1]}, 9, 1'b1);
      bus(0, 4'hC, 0);
      check(q, {23'h0, 1'b1, d[1]});
      bus(0, 4'h0, 0);
      check(q[0], 1'b0);
      $display("address detect test done");
      bus(1, 4'h4, 0);
      bus(1, 4'h0, 32'h0C00);
      uart_sc_peer_i.max_low = 0;
      bus(1, 4'h8, 0);
      for (int w = 0; w < 1000; w++) begin
         bus(0, 4'h0, 0);
         if (q[11] === 1'b0) break;
      end
      check(q[11], 1'b0);
      repeat (40) @(posedge clk);
      check(uart_sc_peer_i.max_low >= 207 && uart_sc_peer_i.max_low <= 208, 1'b1);
      $display("break test done");
      for (int k = 0; k < 4; k++) begin
         bus(1, 4'h4, {19'h0, k[1], 12'h0});
         bus(1, 4'h0, {16'h0, 1'b0, k[0], 14'h0400});
         repeat (4) @(posedge clk);
         check(pin, k[0] ^ !k[1]);
      end
      $display("idle polarity test done");
      complete_run();
   end
endmodule
bind uart_status_control uart_sc_props uart_sc_props_i (.CLK_SYS_IN(CLK_SYS_IN), .RST_B_IN(RST_B_IN),
   .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
   .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
   .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
   .SERIAL_OUT_OE_OUT(SERIAL_OUT_OE_OUT), .TX_IRQ_OUT(TX_IRQ_OUT), .RX_IRQ_OUT(RX_IRQ_OUT));
